/* File: src/fault_reaction_map.svh */
`ifndef FAULT_REACTION_MAP_SVH
`define FAULT_REACTION_MAP_SVH

// register byte offsets
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_IRQ_STATUS  4'h8
`define REG_IRQ_MASK    4'hC
`define REG_TO_DELAY    5'h10
`define REG_BRK_DELAY   5'h14
`define ADDR_W          5

// control register fields
`define CTRL_STAGED     0
`define CTRL_LOWER      1
`define CTRL_ACK        2
`define CTRL_TO_REQ     3
`define CTRL_SINGLE_REQ 4
`define CTRL_BRAKE_REQ  5
`define CTRL_RESET      6'h00

// status register fields
`define ST_LATCHED      0
`define ST_FUNC         1
`define ST_CH_UPPER     2
`define ST_CH_LOWER     3
`define ST_BRAKE        4
`define ST_SAFE_BOTH    5
`define ST_SAFE_SINGLE  6
`define ST_SAFE_BRAKE   7

// interrupt events
`define EV_LATCHED      0
`define EV_FUNC         1
`define EV_SAFE         2
`define EV_W            3

// delays: torque-off delay in clock cycles, brake delay in microseconds
`define DELAY_W         16
`define CLK_MHZ         250
`define US_CNT_W        8
`define US_CYCLES       8'(`CLK_MHZ - 1)

`endif

/* File: src/fault_reaction_pkg.sv */
package fault_reaction_pkg;
  typedef enum logic [1:0] {
    RUN,
    FUNC_FAULT,
    LATCHED_FAULT
  } mode_t;

  // reaction configuration bundle
  typedef struct packed {
    logic        staged;
    logic        lower_first;
    logic [15:0] torque_off_delay;
    logic [15:0] brake_delay_us;
  } reaction_cfg_t;

  // drive outputs bundle
  typedef struct packed {
    logic upper_switch_channel;
    logic lower_switch_channel;
    logic safe_brake_output_control;
  } drive_t;
endpackage

/* File: src/drive_safety_fault_reaction.sv */
`include "fault_reaction_map.svh"

module drive_safety_fault_reaction
  import fault_reaction_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [`ADDR_W-1:0]         wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       hw_fault_i,
  input  wire logic                       limit_error_i,
  input  wire logic                       encoder_error_i,
  input  wire logic                       encoder_needed_i,
  input  wire logic                       torque_off_request_i,
  output fault_reaction_pkg::drive_t      drive_o,
  output logic                            safety_error_indicator_o,
  output logic                            irq_o
);
  import fault_reaction_pkg::*;

  mode_t         mode;
  reaction_cfg_t cfg;
  logic [5:0]    ctrl;
  logic [`EV_W-1:0] irq_status;
  logic [`EV_W-1:0] irq_mask;
  logic [`DELAY_W-1:0] to_cnt;
  logic [`DELAY_W-1:0] brk_cnt;
  logic [`US_CNT_W-1:0] us_cnt;
  logic          to_done;
  logic          brk_done;
  logic          func_entry;
  logic          wr;
  logic          rd;
  logic          ack_clr;
  logic [31:0]   wdata;
  logic [`EV_W-1:0] ev;
  logic          safe_both;
  logic          safe_single;
  logic          safe_brake;
  logic [7:0]    status_vec;
  drive_t        next_drive;
  logic [`DELAY_W-1:0] to_delay;
  logic [`DELAY_W-1:0] brk_delay;
  logic          wr_ctrl;
  logic          wr_to;
  logic          wr_brk;
  logic          wr_ists;
  logic          wr_mask;
  logic [`EV_W-1:0] next_irq_status;


  // byte-lane merge of write data into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // low half of a merged word, for the 16-bit delay registers
  function automatic logic [15:0] merge_half(input logic [15:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] full;
    full = merge({16'h0000, old}, nw, sel);
    return full[15:0];
  endfunction

  // register offset decode, shared by every write path
  function automatic logic reg_hit(input logic [`ADDR_W-1:0] adr,
                                   input logic [`ADDR_W-1:0] off);
    return adr == off;
  endfunction


  // bus strobes, answer one cycle after request
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign wdata = wb_dat_i;

  // per-register write strobes, lane 0 gates the narrow registers
  assign wr_ctrl = wr && reg_hit(wb_adr_i, `ADDR_W'(`REG_CTRL)) && wb_sel_i[0];
  assign wr_to   = wr && reg_hit(wb_adr_i, `REG_TO_DELAY);
  assign wr_brk  = wr && reg_hit(wb_adr_i, `REG_BRK_DELAY);
  assign wr_ists = wr && reg_hit(wb_adr_i, `ADDR_W'(`REG_IRQ_STATUS)) && wb_sel_i[0];
  assign wr_mask = wr && reg_hit(wb_adr_i, `ADDR_W'(`REG_IRQ_MASK)) && wb_sel_i[0];
  assign ack_clr = wr_ctrl && wdata[`CTRL_ACK];


  // functional fault entry, encoder error only counts when needed
  assign func_entry = limit_error_i || (encoder_error_i && encoder_needed_i);


  // fault mode machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= RUN;
    end else begin
      case (mode)
        RUN: begin
          if (hw_fault_i) begin
            mode <= LATCHED_FAULT;
          end else if (func_entry) begin
            mode <= FUNC_FAULT;
          end
        end
        FUNC_FAULT: begin
          if (hw_fault_i) begin
            mode <= LATCHED_FAULT;
          end else if (ack_clr && !func_entry) begin
            mode <= RUN;
          end
        end
        LATCHED_FAULT: begin
          mode <= LATCHED_FAULT;
        end
        default: begin
          mode <= LATCHED_FAULT;
        end
      endcase
    end
  end


  // control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= wdata[5:0];
      ctrl[`CTRL_ACK] <= 1'b0;
    end
  end


  // delay registers, zero after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_delay  <= '0;
      brk_delay <= '0;
    end else begin
      if (wr_to) begin
        to_delay <= merge_half(to_delay, wdata, wb_sel_i);
      end
      if (wr_brk) begin
        brk_delay <= merge_half(brk_delay, wdata, wb_sel_i);
      end
    end
  end

  // configuration bundle seen by the reaction logic
  assign cfg.staged           = ctrl[`CTRL_STAGED];
  assign cfg.lower_first      = ctrl[`CTRL_LOWER];
  assign cfg.torque_off_delay = to_delay;
  assign cfg.brake_delay_us   = brk_delay;


  // torque-off delay counter, cycles from error detection
  always_ff @(posedge clk_i) begin
    if (rst_i || mode != FUNC_FAULT) begin
      to_cnt <= '0;
    end else if (!to_done) begin
      to_cnt <= to_cnt + `DELAY_W'(1);
    end
  end
  assign to_done = (mode == FUNC_FAULT) && (to_cnt >= cfg.torque_off_delay);


  // brake-engage delay, counted in microseconds after the brake output is cut
  always_ff @(posedge clk_i) begin
    if (rst_i || !to_done) begin
      us_cnt  <= '0;
      brk_cnt <= '0;
    end else if (!brk_done) begin
      if (us_cnt == `US_CYCLES) begin
        us_cnt  <= '0;
        brk_cnt <= brk_cnt + `DELAY_W'(1);
      end else begin
        us_cnt <= us_cnt + `US_CNT_W'(1);
      end
    end
  end
  assign brk_done = to_done && (brk_cnt >= cfg.brake_delay_us);


  // output decision, 1 means energised / enabled, 0 means 0 V
  always_comb begin
    next_drive = '{upper_switch_channel: 1'b1, lower_switch_channel: 1'b1,
                   safe_brake_output_control: 1'b1};
    case (mode)
      LATCHED_FAULT: begin
        next_drive = '0;
      end
      FUNC_FAULT: begin
        if (!cfg.staged) begin
          next_drive = '0;
        end else begin
          next_drive.upper_switch_channel = cfg.lower_first;
          next_drive.lower_switch_channel = !cfg.lower_first;
          if (to_done) begin
            next_drive.safe_brake_output_control = 1'b0;
          end
          if (brk_done) begin
            next_drive.upper_switch_channel = 1'b0;
            next_drive.lower_switch_channel = 1'b0;
          end
          // a torque-off request still cuts both channels mid-reaction
          if (torque_off_request_i || ctrl[`CTRL_TO_REQ]) begin
            next_drive.upper_switch_channel = 1'b0;
            next_drive.lower_switch_channel = 1'b0;
          end
        end
      end
      default: begin
        if (torque_off_request_i || ctrl[`CTRL_TO_REQ]) begin
          next_drive.upper_switch_channel = 1'b0;
          next_drive.lower_switch_channel = 1'b0;
        end else if (ctrl[`CTRL_SINGLE_REQ]) begin
          next_drive.upper_switch_channel = cfg.lower_first;
          next_drive.lower_switch_channel = !cfg.lower_first;
        end
        if (ctrl[`CTRL_BRAKE_REQ]) begin
          next_drive.safe_brake_output_control = 1'b0;
        end
      end
    endcase
  end


  // registered drive outputs and indicator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_o <= '0;
      safety_error_indicator_o <= 1'b0;
    end else begin
      drive_o <= next_drive;
      safety_error_indicator_o <= (mode == LATCHED_FAULT);
    end
  end


  // safe-state bits from the actual outputs
  assign safe_both = !drive_o.upper_switch_channel && !drive_o.lower_switch_channel;
  assign safe_single = cfg.lower_first ? !drive_o.lower_switch_channel
                                       : !drive_o.upper_switch_channel;
  assign safe_brake = !drive_o.safe_brake_output_control;
  assign status_vec = {safe_brake, safe_single, safe_both, !drive_o.safe_brake_output_control,
                       drive_o.lower_switch_channel, drive_o.upper_switch_channel,
                       mode == FUNC_FAULT, mode == LATCHED_FAULT};


  // sticky events, set wins over write-one-clear
  assign ev = {safe_both, mode == FUNC_FAULT, mode == LATCHED_FAULT};
  always_comb begin
    next_irq_status = irq_status | ev;
    if (wr_ists) begin
      next_irq_status = (irq_status & ~wdata[`EV_W-1:0]) | ev;
    end
  end

  // interrupt status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // interrupt mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= '0;
    end else if (wr_mask) begin
      irq_mask <= wdata[`EV_W-1:0];
    end
  end


  // interrupt level output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end


  // bus answer and read mux, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wr || rd;
      if (rd) begin
        case (wb_adr_i)
          `ADDR_W'(`REG_CTRL):       wb_dat_o <= {26'h0, ctrl};
          `ADDR_W'(`REG_STATUS):     wb_dat_o <= {24'h0, status_vec};
          `ADDR_W'(`REG_IRQ_STATUS): wb_dat_o <= {29'h0, irq_status};
          `ADDR_W'(`REG_IRQ_MASK):   wb_dat_o <= {29'h0, irq_mask};
          `REG_TO_DELAY:             wb_dat_o <= {16'h0, cfg.torque_off_delay};
          `REG_BRK_DELAY:            wb_dat_o <= {16'h0, cfg.brake_delay_us};
          default:                   wb_dat_o <= '0;
        endcase
      end else begin
        wb_dat_o <= '0;
      end
    end
  end
endmodule

/* File: test/fault_reaction_chk.sv */
module fault_reaction_chk
  import fault_reaction_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic                  hw_fault_i,
  input wire logic                  limit_error_i,
  input wire logic                  encoder_error_i,
  input wire logic                  encoder_needed_i,
  input wire logic                  torque_off_request_i,
  input fault_reaction_pkg::drive_t drive_o,
  input wire logic                  safety_error_indicator_o
);
  // single clock domain
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // latched fault reaction
  a_latch_off: assert property (hw_fault_i |-> ##2 drive_o == 3'h0)
    else $error("drive on in latched fault");
  a_lamp_steady: assert property (hw_fault_i |-> ##2 safety_error_indicator_o [*8])
    else $error("indicator not steady");
  a_latch_hold: assert property (safety_error_indicator_o |=> safety_error_indicator_o)
    else $error("latched fault left");
  // functional fault and torque-off trips
  a_limit_trip: assert property (limit_error_i |-> ##2 drive_o[2:1] != 2'h3)
    else $error("limit did not trip");
  a_encoder_trip: assert property (
    encoder_error_i && encoder_needed_i |-> ##2 drive_o[2:1] != 2'h3)
    else $error("encoder error did not trip");
  a_torque_off: assert property (torque_off_request_i |-> ##1 drive_o[2:1] == 2'h0)
    else $error("torque request left a channel on");
  // bus answer timing
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
endmodule

bind drive_safety_fault_reaction fault_reaction_chk chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .hw_fault_i(hw_fault_i),
  .limit_error_i(limit_error_i), .encoder_error_i(encoder_error_i),
  .encoder_needed_i(encoder_needed_i), .torque_off_request_i(torque_off_request_i),
  .drive_o(drive_o), .safety_error_indicator_o(safety_error_indicator_o));

/* File: test/power_stage_model.sv */
module power_stage_model
  import fault_reaction_pkg::*;
(
  input wire logic                  clk_i,
  input fault_reaction_pkg::drive_t drive_i,
  output logic [19:0]               t_brake_o,
  output logic [19:0]               t_both_o
);
  logic [19:0] cnt;
  // cycles since the first output dropped, then gaps to brake and last channel
  always_ff @(posedge clk_i) begin
    if (drive_i == 3'h7) begin
      cnt <= 20'h0;
      t_brake_o <= 20'h0;
      t_both_o <= 20'h0;
    end else begin
      cnt <= cnt + 20'h1;
      if (drive_i.safe_brake_output_control) t_brake_o <= cnt + 20'h1;
      if (drive_i[2:1] != 2'h0) t_both_o <= cnt + 20'h1;
    end
  end
endmodule

/* File: test/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fault_reaction_pkg::*;
  logic        clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, hw = 1'h0;
  logic        lim = 1'h0, enc = 1'h0, need = 1'h0, tor = 1'h0, ack, lamp, irq;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0, rd, q;
  logic [19:0] tb, tc;
  drive_t      drv;
  int          n_fail = 0, check_count = 0, cycles = 0;
  // 250 MHz clock
  always #2 clk_i = ~clk_i;
  drive_safety_fault_reaction dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .hw_fault_i(hw), .limit_error_i(lim), .encoder_error_i(enc), .encoder_needed_i(need),
    .torque_off_request_i(tor), .drive_o(drv), .safety_error_indicator_o(lamp), .irq_o(irq));
  power_stage_model ps (.clk_i(clk_i), .drive_i(drv), .t_brake_o(tb), .t_both_o(tc));
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1);
    q = rd;
    cyc <= 1'h0;
    stb <= 1'h0;
    chk("ack delay", 2, n);
  endtask
  task automatic wait_drive(input logic [2:0] exp);
    int n = 0;
    while (drv !== exp && n < 400) begin
      step(1);
      n++;
    end
    chk("drive", exp, drv);
  endtask
  task automatic recover(input logic [31:0] cfg);
    @(posedge clk_i);
    lim <= 1'h0;
    enc <= 1'h0;
    tor <= 1'h0;
    wb(1, 5'h00, cfg | 32'h4);
    wait_drive(3'h7);
    wb(1, 5'h08, 32'hFF);
    step(1);
  endtask
  // scenarios
  task automatic t_reset();
    need <= 1'h0;
    enc <= 1'h1;
    wait_drive(3'h7);
    wb(0, 5'h00, 0);
    chk("ctrl", 0, q);
    wb(0, 5'h14, 0);
    chk("brake delay", 0, q);
    wb(0, 5'h18, 0);
    chk("unmapped", 0, q);
    enc <= 1'h0;
  endtask
  task automatic t_immediate();
    @(posedge clk_i);
    lim <= 1'h1;
    step(2);
    chk("immediate", 0, drv);
    wb(0, 5'h04, 0);
    chk("func bit", 1, q[1]);
    chk("irq before mask", 0, irq);
    wb(1, 5'h0C, 32'h2);
    step(1);
    chk("irq mask", 1, irq);
    recover(0);
    chk("irq clear", 0, irq);
  endtask
  task automatic t_staged(input logic [31:0] cfg, input logic [15:0] t, input logic [15:0] b,
                          input logic src);
    wb(1, 5'h00, cfg);
    wb(1, 5'h10, t);
    wb(1, 5'h14, b);
    wb(0, 5'h10, 0);
    chk("delay", t, q);
    @(posedge clk_i);
    need <= src;
    enc <= src;
    lim <= !src;
    step(2);
    chk("first", (t == 0 && b == 0) ? 3'h0 : (cfg[1] ? 3'h5 : 3'h3), drv);
    wait_drive(3'h0);
    chk("brake gap", t, tb);
    chk("channel gap", 1, tc >= t + b * 250 && tc <= t + b * 250 + 1);
    wb(0, 5'h04, 0);
    chk("single safe", 1, q[6]);
    recover(0);
  endtask
  task automatic t_torque();
    @(posedge clk_i);
    tor <= 1'h1;
    step(2);
    chk("torque off", 0, drv[2:1]);
    wb(0, 5'h04, 0);
    chk("safe both", 1, q[5]);
    recover(0);
  endtask
  task automatic t_latched();
    @(posedge clk_i);
    hw <= 1'h1;
    step(2);
    hw <= 1'h0;
    chk("latched", 0, drv);
    wb(1, 5'h00, 32'h4);
    step(8);
    chk("stays latched", 0, drv);
    chk("lamp", 1, lamp);
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    wait_drive(3'h7);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_immediate();
    t_staged(32'h1, 16'h0014, 16'h0001, 1'h1);
    t_staged(32'h3, 16'h0005, 16'h0000, 1'h0);
    t_staged(32'h1, 16'h0000, 16'h0000, 1'h0);
    t_torque();
    t_latched();
    end_of_test();
  end
endmodule
